// >>> src/ris_pkg.sv
// Constants and carriers for the clock interrupt status block
package ris_pkg;
  // Index/data port pair and status register index
  localparam logic [15:0] RIS_INDEX_PORT   = 16'h0070;
  localparam logic [15:0] RIS_DATA_PORT    = 16'h0071;
  localparam logic [6:0]  RIS_STATUS_INDEX = 7'h0c;
  localparam logic [6:0]  RIS_INDEX_RESET  = 7'h00;
  // Field positions inside rtc_irq_status
  localparam int RIS_SUMMARY_BIT  = 7;
  localparam int RIS_PERIODIC_BIT = 6;
  localparam int RIS_ALARM_BIT    = 5;
  localparam int RIS_UPDATE_BIT   = 4;
  localparam logic [3:0] RIS_RESERVED_VAL = 4'h0;
  localparam logic [7:0] RIS_STATUS_RESET = 8'h00;
  // Alarm fields at or above this value match anything
  localparam logic [7:0] RIS_WILDCARD_MIN = 8'hc0;
  // Periodic divider: counter width and reset value
  localparam int RIS_DIV_W = 15;
  localparam logic [RIS_DIV_W-1:0] RIS_DIV_RESET = 15'h0000;
  localparam logic [3:0] RIS_RATE_OFF = 4'h0;

  // Sticky flags of the status register
  typedef struct packed {
    logic summary;
    logic periodic;
    logic alarm;
    logic update;
  } ris_flags_t;

  // Source enables from control register B, same order as the sources
  typedef struct packed {
    logic periodic;
    logic alarm;
    logic update;
  } ris_enables_t;

  // Current time or alarm setting
  typedef struct packed {
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } ris_time_t;
endpackage : ris_pkg

// >>> src/ris_status.sv
// Interrupt status flags, alarm match and periodic divider of the clock
//
// Function
// - Summary flag sets when an enabled source flag rises from 0 to 1.
// - Summary flag sets when an enable turns on while its flag is set.
// - Summary flag clears on status read and clock-only reset; resets to 0.
// - Interrupt request is active with the summary flag, inactive while it is 0.
// - Source flags clear on status read and on clock-only reset.
// - Periodic flag sets on every periodic event, regardless of its enable.
// - Periodic event interval follows the rate selection field.
// - Alarm flag sets on every alarm event, regardless of its enable.
// - Alarm fires once per second when seconds, minutes, hours all match.
// - Alarm field values from c0 to ff match any current value.
// - Update-done flag sets at the end of every update cycle.
// - Status is reached by index 0c on port 70h, then data port 71h.
`timescale 1ns/1ns
module ris_status (
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  input  wire logic                 RTC_RESET,
  input  wire logic [15:0]          IO_ADDR,
  input  wire logic                 IO_WR,
  input  wire logic                 IO_RD,
  input  wire logic [7:0]           IO_WDATA,
  output logic      [7:0]           IO_RDATA,
  output logic                      IO_RVALID,
  input  wire ris_pkg::ris_enables_t IRQ_ENABLES,
  input  wire logic [3:0]           RATE_SEL,
  input  wire logic                 BASE_TICK,
  input  wire logic                 UPDATE_DONE,
  input  wire ris_pkg::ris_time_t   CUR_TIME,
  input  wire ris_pkg::ris_time_t   ALARM_TIME,
  output logic                      IRQ_REQ
);
  import ris_pkg::*;

  ris_flags_t               flags_q, flags_d;
  ris_enables_t             en_prev_q;
  logic [6:0]               index_q;
  logic [RIS_DIV_W-1:0]     div_q;
  logic [7:0]               rdata_q;
  logic                     rvalid_q;
  logic                     irq_q;
  logic                     status_rd;
  logic                     periodic_ev;
  logic                     alarm_match;
  logic                     alarm_ev;
  ris_enables_t             events;
  ris_enables_t             rising;
  ris_enables_t             en_rise;
  logic                     summary_set;

  // Wildcard-aware compare of one alarm field
  function automatic logic field_match(input logic [7:0] alarm, input logic [7:0] cur);
    field_match = (alarm >= RIS_WILDCARD_MIN) || (alarm == cur);
  endfunction : field_match

  // Divider terminal count for a rate code; code 0 stops the divider
  function automatic logic [RIS_DIV_W-1:0] rate_last(input logic [3:0] rate);
    logic [RIS_DIV_W:0] period;
    period    = (RIS_DIV_W+1)'(1) << (rate - 4'h1);
    rate_last = period[RIS_DIV_W-1:0] - (RIS_DIV_W)'(1);
  endfunction : rate_last

  // status reached through index then data port
  assign status_rd = IO_RD && (IO_ADDR == RIS_DATA_PORT) && (index_q == RIS_STATUS_INDEX);

  // three-field compare, sampled once per second at update end
  assign alarm_match = field_match(ALARM_TIME.seconds, CUR_TIME.seconds)
                    && field_match(ALARM_TIME.minutes, CUR_TIME.minutes)
                    && field_match(ALARM_TIME.hours, CUR_TIME.hours);
  assign alarm_ev    = UPDATE_DONE && alarm_match;

  // periodic event on the divider terminal count
  assign periodic_ev = BASE_TICK && (RATE_SEL != RIS_RATE_OFF) && (div_q >= rate_last(RATE_SEL));

  assign events = '{periodic: periodic_ev, alarm: alarm_ev, update: UPDATE_DONE};

  // a flag cleared by this read counts as 0, so an event now is a rise
  assign rising.periodic = events.periodic && (!flags_q.periodic || status_rd);
  assign rising.alarm    = events.alarm && (!flags_q.alarm || status_rd);
  assign rising.update   = events.update && (!flags_q.update || status_rd);
  assign en_rise         = IRQ_ENABLES & ~en_prev_q;

  // enabled rise; enable turned on over a set flag
  assign summary_set = |(rising & IRQ_ENABLES)
                    || (en_rise.periodic && flags_q.periodic)
                    || (en_rise.alarm && flags_q.alarm)
                    || (en_rise.update && flags_q.update);

  // Next flags: set beats the read clear, clock-only reset beats both
  always_comb begin
    flags_d = status_rd ? ris_flags_t'(RIS_STATUS_RESET[7:4]) : flags_q;
    if (events.periodic) begin
      flags_d.periodic = 1'b1;
    end
    if (events.alarm) begin
      flags_d.alarm = 1'b1;
    end
    if (events.update) begin
      flags_d.update = 1'b1;
    end
    if (summary_set) begin
      flags_d.summary = 1'b1;
    end
    // clock-only reset clears summary; and the sources
    if (RTC_RESET) begin
      flags_d = ris_flags_t'(RIS_STATUS_RESET[7:4]);
    end
  end

  // Sticky status flags
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      flags_q <= ris_flags_t'(RIS_STATUS_RESET[7:4]);
    end else begin
      flags_q <= flags_d;
    end
  end

  // request follows the summary flag from its own flop
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flags_d.summary;
    end
  end

  // Previous enables, for spotting a write that turns one on
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      en_prev_q <= '0;
    end else begin
      en_prev_q <= IRQ_ENABLES;
    end
  end

  // index port latch; bit 7 of the written byte is not ours
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      index_q <= RIS_INDEX_RESET;
    end else if (IO_WR && (IO_ADDR == RIS_INDEX_PORT)) begin
      index_q <= IO_WDATA[6:0];
    end
  end

  // tick divider; restarts on terminal count or when stopped
  always_ff @(posedge CLK) begin
    if (!RST_N || RTC_RESET || (RATE_SEL == RIS_RATE_OFF)) begin
      div_q <= RIS_DIV_RESET;
    end else if (periodic_ev) begin
      div_q <= RIS_DIV_RESET;
    end else if (BASE_TICK) begin
      div_q <= div_q + (RIS_DIV_W)'(1);
    end
  end

  // read data is the flags before the clear; reserved bits read 0
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_q  <= RIS_STATUS_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= status_rd;
      if (status_rd) begin
        rdata_q <= {flags_q, RIS_RESERVED_VAL};
      end
    end
  end

  assign IO_RDATA  = rdata_q;
  assign IO_RVALID = rvalid_q;
  assign IRQ_REQ   = irq_q;

  // Checks
  sequence status_read_s;
    status_rd && !RTC_RESET;
  endsequence

  sequence quiet_s;
    !periodic_ev && !UPDATE_DONE && (en_rise == '0);
  endsequence

  read_clears_all_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (status_read_s and quiet_s) |=> (flags_q == '0))
    else $error("status read did not clear the flags");

  read_old_value_a: assert property (@(posedge CLK) disable iff (!RST_N)
    status_read_s |=> IO_RVALID && (IO_RDATA == {$past(flags_q), RIS_RESERVED_VAL}))
    else $error("status read returned wrong data");

  read_keeps_event_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (status_read_s and UPDATE_DONE) |=> flags_q.update ##1 1'b1)
    else $error("event during read was lost");

  periodic_any_en_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (periodic_ev && !RTC_RESET) |=> flags_q.periodic)
    else $error("periodic flag not set");

  // Stopped divider must leave a clear periodic flag clear
  rate_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    ((RATE_SEL == RIS_RATE_OFF) && !flags_q.periodic) |=> !flags_q.periodic)
    else $error("periodic flag set with rate off");

  alarm_flag_set_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (UPDATE_DONE && alarm_match && !RTC_RESET) |=> flags_q.alarm && flags_q.update)
    else $error("alarm or update flag not set");

  summary_rise_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (|(rising & IRQ_ENABLES) && !RTC_RESET) |=> flags_q.summary && IRQ_REQ)
    else $error("enabled rise did not set summary");

  enable_late_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (en_rise.alarm && flags_q.alarm && !RTC_RESET) |=> flags_q.summary)
    else $error("late enable did not set summary");

  rtc_reset_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
    RTC_RESET |=> (flags_q == '0) && !IRQ_REQ)
    else $error("clock-only reset did not clear");

  irq_tracks_a: assert property (@(posedge CLK) disable iff (!RST_N)
    IRQ_REQ == flags_q.summary)
    else $error("request differs from summary flag");

  irq_rise_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(flags_q.summary) |-> IRQ_REQ)
    else $error("summary rise did not raise request");
endmodule : ris_status

// >>> tb/ris_pic_model.sv
// Interrupt controller stand-in that counts rising request edges
`timescale 1ns/1ns
module ris_pic_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       irq_req,
  output logic      [7:0] rise_count
);
  logic irq_q;
  always_ff @(posedge clk) begin
    irq_q <= irq_req;
    if (!rst_n) begin
      rise_count <= 8'h00;
    end else if (irq_req && !irq_q) begin
      rise_count <= rise_count + 8'h01;
    end
  end
endmodule : ris_pic_model

// >>> tb/tb.sv
// Self-checking bench for the clock interrupt status block
`timescale 1ns/1ns
module tb;
  import ris_pkg::*;
  logic         CLK, RST_N, RTC_RESET, IO_WR, IO_RD, IO_RVALID, IRQ_REQ, BASE_TICK, UPDATE_DONE;
  logic [15:0]  IO_ADDR;
  logic [7:0]   IO_WDATA, IO_RDATA, rises;
  logic [3:0]   RATE_SEL;
  ris_enables_t IRQ_ENABLES;
  ris_time_t    CUR_TIME, ALARM_TIME;
  int           fail_count = 0;
  int           checks_done = 0;
  int           cycles = 0;
  ris_status dut_u (.CLK(CLK), .RST_N(RST_N), .RTC_RESET(RTC_RESET), .IO_ADDR(IO_ADDR),
    .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
    .IO_RVALID(IO_RVALID), .IRQ_ENABLES(IRQ_ENABLES), .RATE_SEL(RATE_SEL),
    .BASE_TICK(BASE_TICK), .UPDATE_DONE(UPDATE_DONE), .CUR_TIME(CUR_TIME),
    .ALARM_TIME(ALARM_TIME), .IRQ_REQ(IRQ_REQ));
  ris_pic_model pic_u (.clk(CLK), .rst_n(RST_N), .irq_req(IRQ_REQ), .rise_count(rises));
  // Compare and count
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  // One-cycle write strobe
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge CLK);
    IO_ADDR = a;
    IO_WDATA = d;
    IO_WR = 1'b1;
    @(negedge CLK);
    IO_WR = 1'b0;
  endtask : wr
  // Data port read; u raises an update event in the same cycle
  task rd(input logic u, input logic v, input logic [7:0] exp);
    @(negedge CLK);
    IO_ADDR = RIS_DATA_PORT;
    IO_RD = 1'b1;
    UPDATE_DONE = u;
    @(negedge CLK);
    IO_RD = 1'b0;
    UPDATE_DONE = 1'b0;
    check("read valid", {7'h00, IO_RVALID}, {7'h00, v});
    if (v) check("status", IO_RDATA, exp);
  endtask : rd
  // One-cycle event pulses
  task ev(input logic b, input logic u);
    @(negedge CLK);
    BASE_TICK = b;
    UPDATE_DONE = u;
    @(negedge CLK);
    BASE_TICK = 1'b0;
    UPDATE_DONE = 1'b0;
  endtask : ev
  task irq(input logic e);
    check("irq request", {7'h00, IRQ_REQ}, {7'h00, e});
  endtask : irq
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // Hang guard, well above the roughly 70 cycles needed
  always @(posedge CLK) begin
    cycles++;
    if (cycles > 2000) begin
      fail_count++;
      finish_test;
    end
  end
  initial begin
    {RST_N, RTC_RESET, IO_WR, IO_RD, BASE_TICK, UPDATE_DONE} = 6'h00;
    IO_ADDR = 16'h0000;
    IO_WDATA = 8'h00;
    IRQ_ENABLES = '0;
    RATE_SEL = 4'h0;
    CUR_TIME = {8'h12, 8'h34, 8'h56};
    ALARM_TIME = {8'h12, 8'h34, 8'h57};
    repeat (6) @(negedge CLK);
    RST_N = 1'b1;
    wr(RIS_INDEX_PORT, 8'h0d);
    rd(1'b0, 1'b0, 8'h00);
    wr(RIS_INDEX_PORT, {1'b0, RIS_STATUS_INDEX});
    rd(1'b0, 1'b1, 8'h00);
    $display("test reset done");
    ev(1'b0, 1'b1);
    irq(1'b0);
    rd(1'b0, 1'b1, 8'h10);
    rd(1'b0, 1'b1, 8'h00);
    IRQ_ENABLES.update = 1'b1;
    ev(1'b0, 1'b1);
    irq(1'b1);
    rd(1'b0, 1'b1, 8'h90);
    irq(1'b0);
    IRQ_ENABLES = '0;
    ev(1'b0, 1'b1);
    IRQ_ENABLES.update = 1'b1;
    @(negedge CLK);
    irq(1'b1);
    rd(1'b0, 1'b1, 8'h90);
    IRQ_ENABLES = '0;
    $display("test summary done");
    ALARM_TIME = {8'hc0, 8'hff, 8'h56};
    ev(1'b0, 1'b1);
    rd(1'b0, 1'b1, 8'h30);
    ALARM_TIME.seconds = 8'h57;
    ev(1'b0, 1'b1);
    rd(1'b0, 1'b1, 8'h10);
    $display("test alarm done");
    ev(1'b1, 1'b0);
    rd(1'b0, 1'b1, 8'h00);
    RATE_SEL = 4'h1;
    ev(1'b1, 1'b0);
    rd(1'b0, 1'b1, 8'h40);
    RATE_SEL = 4'h2;
    // Rate code 2 needs a second tick before the event
    ev(1'b1, 1'b0);
    rd(1'b0, 1'b1, 8'h00);
    ev(1'b1, 1'b0);
    rd(1'b0, 1'b1, 8'h40);
    // Enabled periodic source raises the request
    RATE_SEL = 4'h1;
    IRQ_ENABLES.periodic = 1'b1;
    ev(1'b1, 1'b0);
    irq(1'b1);
    rd(1'b0, 1'b1, 8'hc0);
    irq(1'b0);
    IRQ_ENABLES = '0;
    RATE_SEL = 4'h0;
    $display("test periodic done");
    IRQ_ENABLES.update = 1'b1;
    ev(1'b0, 1'b1);
    RTC_RESET = 1'b1;
    @(negedge CLK);
    RTC_RESET = 1'b0;
    irq(1'b0);
    rd(1'b0, 1'b1, 8'h00);
    // enables cleared before the data-port write and the read racing an update
    IRQ_ENABLES = '0;
    wr(RIS_DATA_PORT, 8'h00);
    rd(1'b1, 1'b1, 8'h00);
    rd(1'b0, 1'b1, 8'h10);
    $display("test reset and read race done");
    check("irq rises", rises, 8'h04);
    finish_test;
  end
endmodule : tb
